// ### src/sscif_slave.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_slave (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // serial pins
    input  wire logic        chip_select_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             sdo_out,
    output logic             sdo_oe,
    // device state
    input  wire logic [15:0] primary_status_reg,
    input  wire logic        parity_check_enable,
    input  wire logic [2:0]  op_mode,
    input  wire logic        sec_read_busy,
    // address checks for req_addr
    input  wire logic        addr_read_allowed,
    input  wire logic        addr_write_allowed,
    input  wire logic        addr_is_secondary,
    input  wire logic [15:0] reg_rd_data,
    // requests out
    output logic [4:0]       req_addr,
    output logic             reg_rd_strobe,
    output logic             reg_wr_strobe,
    output logic [15:0]      reg_wr_data,
    output logic             cfg_entry_cmd,
    output logic             verif_entry_cmd,
    output logic             cfg_exit_cmd,
    // sticky error
    output logic             spi_error_flag,
    input  wire logic        spi_error_clear
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_CHECK
    } sscif_state_t;

    sscif_state_t           state_reg;
    logic                   cs_n_f;
    logic                   sclk_f;
    logic                   sdi_f;
    logic                   cs_prev_reg;
    logic                   sclk_prev_reg;
    logic                   cs_fall;
    logic                   cs_rise;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic [15:0]            shift_reg;
    logic [15:0]            req_word_reg;
    logic                   frame_ok_reg;
    logic [sscif_pkg::CNT_W-1:0] rise_cnt_reg;
    logic [sscif_pkg::CNT_W-1:0] fall_cnt_reg;
    logic                   counts_ok;
    logic [15:0]            wbuf_reg;
    logic [15:0]            ans_data_reg;
    sscif_pkg::sscif_ans_t  ans_sel_reg;
    logic [15:0]            ans_value;
    logic [15:0]            ans_word;
    sscif_pkg::sscif_cmd_t  cmd;
    logic                   fixed_cmd;
    logic [4:0]             dec_addr;
    logic [7:0]             dec_upper;
    logic [5:0]             dec_lower;
    logic                   parity_err;
    logic                   mode_err;
    logic                   addr_err;
    logic                   req_err;
    logic                   in_check;

    // select filter shorter than clock and data
    sscif_debounce #(
        .SAMPLES (sscif_pkg::CS_SAMPLES),
        .RST_VAL (1'b1)
    ) u_cs_filt (
        .clk       (clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .pin_in    (chip_select_n),
        .level_out (cs_n_f)
    );

    sscif_debounce #(
        .SAMPLES (sscif_pkg::DATA_SAMPLES),
        .RST_VAL (1'b0)
    ) u_sclk_filt (
        .clk       (clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .pin_in    (sclk),
        .level_out (sclk_f)
    );

    sscif_debounce #(
        .SAMPLES (sscif_pkg::DATA_SAMPLES),
        .RST_VAL (1'b0)
    ) u_sdi_filt (
        .clk       (clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .pin_in    (sdi),
        .level_out (sdi_f)
    );

    sscif_decode u_decode (
        .word       (req_word_reg),
        .cmd        (cmd),
        .fixed_cmd  (fixed_cmd),
        .addr       (dec_addr),
        .upper_byte (dec_upper),
        .lower_bits (dec_lower)
    );

    // edge history of the filtered levels
    always_ff @(posedge clk) begin
        if (srst) begin
            cs_prev_reg   <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else if (clk_en) begin
            cs_prev_reg   <= cs_n_f;
            sclk_prev_reg <= sclk_f;
        end
    end

    // clock edges count only inside a transfer
    assign cs_fall   = cs_prev_reg & ~cs_n_f; // [RULE23]
    assign cs_rise   = ~cs_prev_reg & cs_n_f;
    assign sclk_rise = (state_reg == ST_ACTIVE) & ~cs_n_f & sclk_f & ~sclk_prev_reg; // [RULE26]
    assign sclk_fall = (state_reg == ST_ACTIVE) & ~cs_n_f & ~sclk_f & sclk_prev_reg; // [RULE26]
    assign in_check  = (state_reg == ST_CHECK);

    // idle, shifting, one evaluation cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= ST_ACTIVE; // [RULE4]
                    end
                end
                ST_ACTIVE: begin
                    if (cs_rise) begin
                        state_reg <= ST_CHECK; // [RULE4]
                    end
                end
                ST_CHECK: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // pending answer, parity regenerated
    always_comb begin
        case (ans_sel_reg)
            sscif_pkg::ANS_DATA: begin
                ans_value = ans_data_reg; // [RULE5]
            end
            sscif_pkg::ANS_INVALID: begin
                ans_value = primary_status_reg; // [RULE14]
                ans_value[sscif_pkg::LMI_BIT] = 1'b1; // [RULE10]
            end
            default: begin
                ans_value = primary_status_reg;
            end
        endcase
        ans_word = {ans_value[15:1], sscif_pkg::sscif_parity(ans_value[15:1])}; // [RULE7]
    end

    // one register both ways, so a daisy chain passes words through
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_reg <= sscif_pkg::WORD_RST;
        end else if (clk_en) begin
            if (state_reg == ST_IDLE && cs_fall) begin
                shift_reg <= ans_word; // [RULE5]
            end else if (sclk_fall) begin
                shift_reg <= {shift_reg[14:0], sdi_f}; // [RULE24]
            end
        end
    end

    // msb presented as soon as the transfer opens
    always_ff @(posedge clk) begin
        if (srst) begin
            sdo_out <= 1'b0;
        end else if (clk_en) begin
            if (state_reg == ST_IDLE && cs_fall) begin
                sdo_out <= ans_word[15];
            end else if (sclk_rise) begin
                sdo_out <= shift_reg[15]; // [RULE24]
            end
        end
    end

    // released while deselected
    assign sdo_oe = ~cs_n_f & (state_reg == ST_ACTIVE); // [RULE26]

    // edge counters restart per transfer
    always_ff @(posedge clk) begin
        if (srst) begin
            rise_cnt_reg <= sscif_pkg::CNT_RST;
            fall_cnt_reg <= sscif_pkg::CNT_RST;
        end else if (clk_en) begin
            if (state_reg == ST_IDLE && cs_fall) begin
                rise_cnt_reg <= sscif_pkg::CNT_RST;
                fall_cnt_reg <= sscif_pkg::CNT_RST;
            end else begin
                if (sclk_rise) begin
                    rise_cnt_reg <= rise_cnt_reg + 1'b1;
                end
                if (sclk_fall) begin
                    fall_cnt_reg <= fall_cnt_reg + 1'b1;
                end
            end
        end
    end

    // an empty transfer counts as wrong length
    assign counts_ok = (rise_cnt_reg == fall_cnt_reg)
                     & (rise_cnt_reg[3:0] == 4'h0)
                     & (rise_cnt_reg != sscif_pkg::CNT_RST); // [RULE25] [RULE3]

    // last sixteen bits in are this device's request
    always_ff @(posedge clk) begin
        if (srst) begin
            req_word_reg <= sscif_pkg::WORD_RST;
            frame_ok_reg <= 1'b0;
            req_addr     <= sscif_pkg::ADDR_RST;
        end else if (clk_en) begin
            if (state_reg == ST_ACTIVE && cs_rise) begin
                req_word_reg <= shift_reg;
                frame_ok_reg <= counts_ok; // [RULE25]
                req_addr     <= shift_reg[sscif_pkg::ADDR_MSB:sscif_pkg::ADDR_LSB];
            end
        end
    end

    // fixed words always need good parity
    assign parity_err = ~sscif_pkg::sscif_parity_ok(req_word_reg)
                      & (parity_check_enable | fixed_cmd); // [RULE8] [RULE9] [RULE11]

    // operating mode admission per command
    always_comb begin
        case (cmd)
            sscif_pkg::CMD_CFG_ENTRY: begin
                mode_err = (op_mode != sscif_pkg::MODE_DEFAULT)
                         & (op_mode != sscif_pkg::MODE_ERROR); // [RULE16] [RULE12]
            end
            sscif_pkg::CMD_VERIF_ENTRY: begin
                mode_err = (op_mode != sscif_pkg::MODE_CONFIG); // [RULE17] [RULE12]
            end
            sscif_pkg::CMD_CFG_EXIT: begin
                mode_err = (op_mode != sscif_pkg::MODE_CONFIG); // [RULE18] [RULE12]
            end
            sscif_pkg::CMD_READ: begin
                mode_err = addr_is_secondary & sec_read_busy; // [RULE12]
            end
            default: begin
                mode_err = 1'b0; // [RULE19]
            end
        endcase
    end

    // address legality judged outside
    always_comb begin
        case (cmd)
            sscif_pkg::CMD_READ: begin
                addr_err = ~addr_read_allowed; // [RULE13]
            end
            sscif_pkg::CMD_WRITE_LOWER: begin
                addr_err = ~addr_write_allowed; // [RULE13]
            end
            default: begin
                addr_err = 1'b0;
            end
        endcase
    end

    assign req_err = ~frame_ok_reg | parity_err | mode_err | addr_err
                   | (cmd == sscif_pkg::CMD_NONE); // [RULE11]

    // next answer selection; status answer right after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            ans_sel_reg  <= sscif_pkg::ANS_STATUS; // [RULE6]
            ans_data_reg <= sscif_pkg::WORD_RST;
        end else if (clk_en) begin
            if (in_check) begin
                if (req_err) begin
                    ans_sel_reg <= sscif_pkg::ANS_INVALID; // [RULE10]
                end else if (cmd == sscif_pkg::CMD_READ) begin
                    ans_sel_reg  <= sscif_pkg::ANS_DATA; // [RULE20]
                    ans_data_reg <= reg_rd_data;
                end else begin
                    ans_sel_reg <= sscif_pkg::ANS_STATUS;
                end
            end
        end
    end

    // write buffer; a rejected request leaves it untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            wbuf_reg <= sscif_pkg::WBUF_RST; // [RULE27]
        end else if (clk_en) begin
            if (in_check && !req_err) begin
                if (cmd == sscif_pkg::CMD_WRITE_UPPER) begin
                    wbuf_reg[15:8] <= dec_upper; // [RULE21]
                end else if (cmd == sscif_pkg::CMD_WRITE_LOWER) begin
                    wbuf_reg <= sscif_pkg::WBUF_RST; // [RULE22]
                end
            end
        end
    end

    // register commit; the two lowest data bits have no field and stay zero
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_wr_strobe <= 1'b0;
            reg_wr_data   <= sscif_pkg::WORD_RST;
        end else if (clk_en) begin
            reg_wr_strobe <= in_check & ~req_err & (cmd == sscif_pkg::CMD_WRITE_LOWER);
            if (in_check && !req_err && cmd == sscif_pkg::CMD_WRITE_LOWER) begin
                reg_wr_data <= {wbuf_reg[15:8], dec_lower, 2'b00}; // [RULE22]
            end
        end
    end

    // one-cycle command pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rd_strobe   <= 1'b0;
            cfg_entry_cmd   <= 1'b0;
            verif_entry_cmd <= 1'b0;
            cfg_exit_cmd    <= 1'b0;
        end else if (clk_en) begin
            reg_rd_strobe   <= in_check & ~req_err & (cmd == sscif_pkg::CMD_READ);
            cfg_entry_cmd   <= in_check & ~req_err & (cmd == sscif_pkg::CMD_CFG_ENTRY);
            verif_entry_cmd <= in_check & ~req_err & (cmd == sscif_pkg::CMD_VERIF_ENTRY);
            cfg_exit_cmd    <= in_check & ~req_err & (cmd == sscif_pkg::CMD_CFG_EXIT);
        end
    end

    // sticky error; a new error wins over a clear
    always_ff @(posedge clk) begin
        if (srst) begin
            spi_error_flag <= 1'b0;
        end else if (clk_en) begin
            if (in_check && req_err) begin
                spi_error_flag <= 1'b1; // [RULE10]
            end else if (spi_error_clear) begin
                spi_error_flag <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/sscif_pkg.sv
// Behaviour
// [RULE1] data and clock levels need three equal samples
// [RULE2] chip select level needs two equal samples
// [RULE3] every word is sixteen shifted bits, both directions
// [RULE4] a transfer runs from chip select falling to its next rise
// [RULE5] a request is answered during the next transfer
// [RULE6] first word after reset is the primary status value
// [RULE7] odd parity in bit zero, always generated when sending
// [RULE8] received parity ignored while checking is disabled
// [RULE9] fixed-value commands need correct parity regardless, else spi error
// [RULE10] bad request discarded, error flag set, answer flags invalid message
// [RULE11] parity error, wrong length or unknown encoding raise spi error
// [RULE12] mode-illegal command or secondary read while busy raise spi error
// [RULE13] read or write to an invalid address raises spi error
// [RULE14] invalid-message answer otherwise carries the primary status
// [RULE15] master should hard-reset the device on persistent invalid answers
// [RULE16] configuration entry 0x1880 only in default or error mode
// [RULE17] verification entry 0x1140 only in configuration mode
// [RULE18] configuration exit 0x1220 only in configuration mode
// [RULE19] no-op 0x1410 valid in every mode, still checked
// [RULE20] read decodes address in bits 11..7, answer returns register value
// [RULE21] upper write loads only the upper byte of the write buffer
// [RULE22] lower write fills low byte, copies buffer to register, clears buffer
// [RULE23] chip select is active low
// [RULE24] output shifts msb first on rising, input captured on falling clock
// [RULE25] at frame end, edge counts must match and be multiples of sixteen
// [RULE26] with chip select inactive, clock and data ignored, output released
// [RULE27] write buffer is zero after reset
package sscif_pkg;
    localparam int          WORD_W        = 16;
    localparam int          CNT_W         = 10;
    localparam int          ADDR_W        = 5;
    localparam int          MODE_W        = 3;
    localparam int          DATA_SAMPLES  = 3;
    localparam int          CS_SAMPLES    = 2;
    localparam int          ADDR_MSB      = 11;
    localparam int          ADDR_LSB      = 7;
    localparam int          LMI_BIT       = 15;
    localparam logic [15:0] CFG_ENTRY_W   = 16'h1880;
    localparam logic [15:0] VERIF_ENTRY_W = 16'h1140;
    localparam logic [15:0] CFG_EXIT_W    = 16'h1220;
    localparam logic [15:0] NOP_W         = 16'h1410;
    localparam logic [15:0] READ_MASK     = 16'hF07E;
    localparam logic [15:0] READ_PAT      = 16'h002A;
    localparam logic [15:0] WRH_MASK      = 16'hFE00;
    localparam logic [15:0] WRH_PAT       = 16'h4400;
    localparam logic [15:0] WRL_MASK      = 16'hF000;
    localparam logic [15:0] WRL_PAT       = 16'hA000;
    localparam logic [15:0] WBUF_RST      = 16'h0000;
    localparam logic [15:0] WORD_RST      = 16'h0000;
    localparam logic [4:0]  ADDR_RST      = 5'h00;
    localparam logic [CNT_W-1:0] CNT_RST  = 10'h000;
    localparam logic [2:0]  MODE_DEFAULT  = 3'h0;
    localparam logic [2:0]  MODE_ERROR    = 3'h1;
    localparam logic [2:0]  MODE_CONFIG   = 3'h2;
    localparam logic [2:0]  MODE_CONFIGD  = 3'h3;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_CFG_ENTRY,
        CMD_VERIF_ENTRY,
        CMD_CFG_EXIT,
        CMD_NOP,
        CMD_READ,
        CMD_WRITE_UPPER,
        CMD_WRITE_LOWER
    } sscif_cmd_t;

    typedef enum logic [1:0] {
        ANS_STATUS,
        ANS_DATA,
        ANS_INVALID
    } sscif_ans_t;

    // parity over the payload bits
    function automatic logic sscif_parity(input logic [14:0] payload);
        sscif_parity = ~(^payload);
    endfunction

    // a full word carries odd parity when its xor is one
    function automatic logic sscif_parity_ok(input logic [15:0] word);
        sscif_parity_ok = ^word;
    endfunction
endpackage

// ### src/sscif_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_debounce #(
    parameter int   SAMPLES = 3,
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      level_out
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic [2:0] same_cnt_reg;

    // two-stage synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= RST_VAL;
            sync2_reg <= RST_VAL;
        end else if (clk_en) begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // new level taken only after SAMPLES equal samples; shorter pulses drop out
    always_ff @(posedge clk) begin
        if (srst) begin
            level_out    <= RST_VAL;
            same_cnt_reg <= 3'h0;
        end else if (clk_en) begin
            if (sync2_reg == level_out) begin
                same_cnt_reg <= 3'h0;
            end else if (same_cnt_reg == 3'(SAMPLES - 1)) begin
                level_out    <= sync2_reg; // [RULE1] [RULE2]
                same_cnt_reg <= 3'h0;
            end else begin
                same_cnt_reg <= same_cnt_reg + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/sscif_decode.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_decode (
    input  wire logic [15:0]        word,
    output sscif_pkg::sscif_cmd_t   cmd,
    output logic                    fixed_cmd,
    output logic [4:0]              addr,
    output logic [7:0]              upper_byte,
    output logic [5:0]              lower_bits
);
    // fields common to every command
    assign addr       = word[sscif_pkg::ADDR_MSB:sscif_pkg::ADDR_LSB];
    assign upper_byte = word[8:1];
    assign lower_bits = word[6:1];

    // fixed words compare without parity bit
    always_comb begin
        cmd       = sscif_pkg::CMD_NONE;
        fixed_cmd = 1'b1;
        if (word[15:1] == sscif_pkg::CFG_ENTRY_W[15:1]) begin
            cmd = sscif_pkg::CMD_CFG_ENTRY; // [RULE16]
        end else if (word[15:1] == sscif_pkg::VERIF_ENTRY_W[15:1]) begin
            cmd = sscif_pkg::CMD_VERIF_ENTRY; // [RULE17]
        end else if (word[15:1] == sscif_pkg::CFG_EXIT_W[15:1]) begin
            cmd = sscif_pkg::CMD_CFG_EXIT; // [RULE18]
        end else if (word[15:1] == sscif_pkg::NOP_W[15:1]) begin
            cmd = sscif_pkg::CMD_NOP; // [RULE19]
        end else begin
            fixed_cmd = 1'b0;
            if ((word & sscif_pkg::READ_MASK) == sscif_pkg::READ_PAT) begin
                cmd = sscif_pkg::CMD_READ; // [RULE20]
            end else if ((word & sscif_pkg::WRH_MASK) == sscif_pkg::WRH_PAT) begin
                cmd = sscif_pkg::CMD_WRITE_UPPER; // [RULE21]
            end else if ((word & sscif_pkg::WRL_MASK) == sscif_pkg::WRL_PAT) begin
                cmd = sscif_pkg::CMD_WRITE_LOWER; // [RULE22]
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/sscif_slave_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_slave_monitor (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       chip_select_n,
    input wire logic       sdo_oe,
    input wire logic [2:0] op_mode,
    input wire logic       sec_read_busy,
    input wire logic       addr_is_secondary,
    input wire logic       addr_write_allowed,
    input wire logic       reg_rd_strobe,
    input wire logic       reg_wr_strobe,
    input wire logic       cfg_entry_cmd,
    input wire logic       verif_entry_cmd,
    input wire logic       cfg_exit_cmd,
    input wire logic       spi_error_flag,
    input wire logic       spi_error_clear
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // eight cycles cover sync and filter
    AST_OE_IDLE: assert property (chip_select_n [*8] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    AST_OE_SEL: assert property (!chip_select_n [*8] |-> sdo_oe)
        else $error("sdo released while selected");
    // actions only after frame close
    AST_AFTER_FRAME: assert property (
        (cfg_entry_cmd || reg_rd_strobe || reg_wr_strobe) |-> $past(chip_select_n, 5))
        else $error("action before frame end");
    AST_ENTRY: assert property (
        cfg_entry_cmd |-> (op_mode == 3'h0 || op_mode == 3'h1))
        else $error("entry in wrong mode");
    AST_VERIF: assert property (verif_entry_cmd |-> op_mode == 3'h2)
        else $error("verification entry in wrong mode");
    AST_EXIT: assert property (cfg_exit_cmd |-> op_mode == 3'h2)
        else $error("exit in wrong mode");
    AST_STICKY: assert property (spi_error_flag && !spi_error_clear |=> spi_error_flag)
        else $error("error flag dropped");
    AST_BUSY: assert property (
        reg_rd_strobe |-> !($past(addr_is_secondary) && $past(sec_read_busy)))
        else $error("read issued while busy");
    AST_WR_ADDR: assert property (reg_wr_strobe |-> $past(addr_write_allowed))
        else $error("write to refused address");
    cover property (cfg_exit_cmd);
    cover property (reg_wr_strobe);
    cover property ($rose(spi_error_flag));
endmodule
`default_nettype wire

// ### dv/sscif_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_master_model (
    input  wire logic clk,
    output logic      chip_select_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        chip_select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // one frame at 160 ns per bit; a short frame sends the top nbits
    task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
        r = 16'h0000;
        @(negedge clk);
        chip_select_n = 1'b0;
        repeat (10) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            sdi = w[15 - i];
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            repeat (4) @(negedge clk);
            r = {r[14:0], sdo};
        end
        repeat (10) @(negedge clk);
        chip_select_n = 1'b1;
        sdi = ~sdi; // no stale last bit
        repeat (15) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ### dv/sscif_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sscif_slave_tb;
    typedef struct packed {
        logic [2:0]  mode;
        logic        pen;
        logic        err;
        logic [4:0]  act;
        logic [15:0] req;
    } sscif_row_t;
    logic        clk, srst, chip_select_n, sclk, sdi, sdo_out, sdo_oe, sdo_line;
    logic        parity_check_enable, busy, wr_ok, sec, rd_stb, wr_stb;
    logic        ent, ver, ext, spi_error_flag, spi_error_clear;
    logic [15:0] primary_status_reg, rd_data, wr_data, exp_ans, nxt;
    logic [4:0]  req_addr, seen;
    logic [2:0]  op_mode;
    int          errors, checks_done;
    sscif_row_t  rows [14];

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // floats when released: no stale bit
    assign sdo_line = sdo_oe ? sdo_out : 1'bz;
    always @(posedge clk) seen <= spi_error_clear ? 5'h00 : (seen | {ent, ver, ext, rd_stb, wr_stb});

    sscif_slave u_sscif_slave (.clk(clk), .srst(srst), .clk_en(1'b1),
        .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .primary_status_reg(primary_status_reg),
        .parity_check_enable(parity_check_enable), .op_mode(op_mode), .sec_read_busy(busy),
        .addr_read_allowed(wr_ok), .addr_write_allowed(wr_ok), .addr_is_secondary(sec),
        .reg_rd_data(rd_data), .req_addr(req_addr), .reg_rd_strobe(rd_stb),
        .reg_wr_strobe(wr_stb), .reg_wr_data(wr_data), .cfg_entry_cmd(ent),
        .verif_entry_cmd(ver), .cfg_exit_cmd(ext), .spi_error_flag(spi_error_flag),
        .spi_error_clear(spi_error_clear));
    sscif_master_model u_sscif_master_model (.clk(clk), .chip_select_n(chip_select_n),
        .sclk(sclk), .sdi(sdi), .sdo(sdo_line));

    // odd parity in bit zero
    function automatic logic [15:0] ans(input logic [15:0] v);
        return {v[15:1], ~^v[15:1]};
    endfunction
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic run(input sscif_row_t t, input int nbits);
        logic [15:0] r;
        @(negedge clk);
        op_mode = t.mode;
        parity_check_enable = t.pen;
        spi_error_clear = 1'b1;
        @(negedge clk);
        spi_error_clear = 1'b0;
        u_sscif_master_model.xfer(t.req, nbits, r);
        if (nbits == 16) check("answer", r, exp_ans);
        check("error", {15'h0000, spi_error_flag}, {15'h0000, t.err});
        check("action", {11'h000, seen}, {11'h000, t.act});
        nxt = t.act[1] ? rd_data : primary_status_reg;
        exp_ans = t.err ? ans(primary_status_reg | 16'h8000) : ans(nxt);
        $display("test req %h done", t.req);
    endtask

    initial begin
        #500000;
        errors++;
        report_and_stop();
    end
    initial begin
        srst = 1'b1;
        {parity_check_enable, busy, wr_ok, sec, spi_error_clear} = 5'h04;
        op_mode = 3'h0;
        primary_status_reg = 16'h0246;
        rd_data = 16'h5A3C;
        errors = 0;
        checks_done = 0;
        exp_ans = ans(16'h0246);
        // mode, parity check, error, actions, request
        rows = '{'{3'h0, 1'h1, 1'h0, 5'h10, 16'h1880}, '{3'h1, 1'h1, 1'h0, 5'h10, 16'h1880},
                 '{3'h3, 1'h1, 1'h1, 5'h00, 16'h1880}, '{3'h2, 1'h1, 1'h0, 5'h08, 16'h1140},
                 '{3'h0, 1'h1, 1'h1, 5'h00, 16'h1140}, '{3'h2, 1'h1, 1'h0, 5'h04, 16'h1220},
                 '{3'h3, 1'h1, 1'h1, 5'h00, 16'h1220}, '{3'h5, 1'h1, 1'h0, 5'h00, 16'h1410},
                 '{3'h0, 1'h0, 1'h1, 5'h00, 16'h1411}, '{3'h0, 1'h1, 1'h1, 5'h00, 16'h08AB},
                 '{3'h0, 1'h0, 1'h0, 5'h02, 16'h08AB}, '{3'h0, 1'h1, 1'h1, 5'h00, 16'hFFFF},
                 '{3'h0, 1'h1, 1'h0, 5'h00, 16'h4587}, '{3'h0, 1'h1, 1'h0, 5'h01, 16'hA8DB}};
        repeat (8) @(negedge clk);
        srst = 1'b0;
        foreach (rows[i]) run(rows[i], 16);
        check("wr data", wr_data, 16'hC3B4);
        check("addr", {11'h000, req_addr}, 16'h0011);
        wr_ok = 1'b0;
        run('{3'h0, 1'h1, 1'h1, 5'h00, 16'hA8DB}, 16);
        run('{3'h0, 1'h1, 1'h1, 5'h00, 16'h08AA}, 16);
        wr_ok = 1'b1;
        {sec, busy} = 2'h3;
        run('{3'h0, 1'h1, 1'h1, 5'h00, 16'h08AA}, 16);
        {sec, busy} = 2'h0;
        run('{3'h0, 1'h1, 1'h1, 5'h00, 16'h1410}, 15);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        check("reset", {14'h0000, sdo_oe, spi_error_flag}, 16'h0000);
        exp_ans = ans(16'h0246);
        run('{3'h0, 1'h1, 1'h0, 5'h01, 16'hA8DB}, 16);
        check("wr data", wr_data, 16'h00B4);
        report_and_stop();
    end
endmodule
bind sscif_slave sscif_slave_monitor u_sscif_slave_monitor (.clk(clk), .srst(srst),
    .chip_select_n(chip_select_n), .sdo_oe(sdo_oe), .op_mode(op_mode),
    .sec_read_busy(sec_read_busy), .addr_is_secondary(addr_is_secondary),
    .addr_write_allowed(addr_write_allowed), .reg_rd_strobe(reg_rd_strobe),
    .reg_wr_strobe(reg_wr_strobe), .cfg_entry_cmd(cfg_entry_cmd),
    .verif_entry_cmd(verif_entry_cmd), .cfg_exit_cmd(cfg_exit_cmd),
    .spi_error_flag(spi_error_flag), .spi_error_clear(spi_error_clear));
`default_nettype wire
